// File: src/ebp_pkg.sv
// Package for the eight-bit port with peripheral overrides.
package ebp_pkg;

   // Register byte addresses on the APB bus.
   localparam logic [7:0] EBP_PIN_LEVEL_OFS  = 8'h00;
   localparam logic [7:0] EBP_LATCH_OFS      = 8'h04;
   localparam logic [7:0] EBP_DIR_OFS        = 8'h08;
   localparam logic [7:0] EBP_CONV_CFG_OFS   = 8'h0C;
   localparam logic [7:0] EBP_MEM_CTRL_OFS   = 8'h10;
   localparam logic [7:0] EBP_PIN_CFG_OFS    = 8'h14;

   // Field positions.
   localparam int EBP_EXT_BUS_DIS_BIT = 7;
   localparam int EBP_REMAP_BIT       = 0;
   localparam int EBP_SHDN_TRI_BIT    = 1;
   localparam int EBP_SMALL_PKG_BIT   = 2;

   // Values after reset.
   localparam logic [7:0] EBP_LATCH_RST    = 8'h00;
   localparam logic [7:0] EBP_DIR_RST      = 8'hFF;
   localparam logic [3:0] EBP_CONV_CFG_RST = 4'h0;
   localparam logic [7:0] EBP_MEM_CTRL_RST = 8'h80;
   localparam logic [2:0] EBP_PIN_CFG_RST  = 3'h1;

   // Synchroniser depth for pin inputs.
   localparam int EBP_SYNC_STAGES = 2;

   // Pin drive bundle toward the pads.
   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe;
   } ebp_pad_t;

   // Peripheral signals that may take over pins.
   typedef struct packed {
      logic [3:0] ext_addr;
      logic       pwm_one_out_b;
      logic       pwm_one_out_c;
      logic       pwm_three_out_b;
      logic       pwm_three_out_c;
      logic       pwm_one_shutdown;
      logic       pwm_three_shutdown;
   } ebp_periph_t;

endpackage

// File: src/ebp_port.sv
// Eight-bit bidirectional port with memory and PWM overrides and converter channel selection.
`timescale 1ns/1ps
module ebp_port
   import ebp_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input  wire logic              core_clk_in,
   input  wire logic              rst_n_in,
   // APB slave.
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [7:0]        paddr_in,
   input  wire logic [31:0]       pwdata_in,
   input  wire logic [3:0]        pstrb_in,
   output logic      [31:0]       prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   // Peripheral functions.
   input  wire ebp_periph_t       periph_in,
   input  wire logic              parallel_slave_port_en_in,
   input  wire logic [WIDTH-1:0]  parallel_slave_port_data_in,
   // Pads.
   input  wire logic [WIDTH-1:0]  pad_in,
   output ebp_pad_t               pad_out,
   // Status toward other blocks.
   output logic [3:0]             analog_sel_out,
   output logic [3:0]             alt_port_pwm_out,
   output logic                   ext_bus_active_out
);

   logic [WIDTH-1:0] h_output_latch_ff;
   logic [WIDTH-1:0] h_direction_bits_ff;
   logic [3:0]       analog_pin_config_ff;
   logic [7:0]       memory_ctrl_reg_ff;
   logic [2:0]       pin_cfg_ff;
   logic [WIDTH-1:0] sync0_ff;
   logic [WIDTH-1:0] h_pin_level_reg_ff;
   ebp_pad_t         pad_ff;
   logic [31:0]      prdata_ff;
   logic             pready_ff;
   logic             pslverr_ff;
   logic [3:0]       analog_sel_ff;
   logic [3:0]       alt_pwm_ff;
   logic             ext_bus_ff;

   // Byte-lane merge used by the latch, direction and memory control registers.
   function automatic logic [7:0] merge_lane(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic lane);
      merge_lane = lane ? new_v : old_v;
   endfunction

   wire logic setup_w   = psel_in && !penable_in;
   // Writes land on the access edge, when the master sees ready high, never on setup.
   wire logic access_w  = psel_in && penable_in && pready_ff;
   wire logic wr_w      = access_w && pwrite_in && pstrb_in[0];
   wire logic hit_pin_w = paddr_in == EBP_PIN_LEVEL_OFS;
   wire logic hit_lat_w = paddr_in == EBP_LATCH_OFS;
   wire logic hit_dir_w = paddr_in == EBP_DIR_OFS;
   wire logic hit_cnv_w = paddr_in == EBP_CONV_CFG_OFS;
   wire logic hit_mem_w = paddr_in == EBP_MEM_CTRL_OFS;
   wire logic hit_cfg_w = paddr_in == EBP_PIN_CFG_OFS;
   wire logic mapped_w  = hit_pin_w | hit_lat_w | hit_dir_w | hit_cnv_w | hit_mem_w | hit_cfg_w;

   wire logic [7:0] wbyte_w = pwdata_in[7:0];

   // The latch register reads back its own flops, not the pads.
   wire logic [31:0] nxt_prdata =
      hit_pin_w ? {24'h000000, h_pin_level_reg_ff} :
      hit_lat_w ? {24'h000000, h_output_latch_ff} :
      hit_dir_w ? {24'h000000, h_direction_bits_ff} :
      hit_cnv_w ? {28'h0000000, analog_pin_config_ff} :
      hit_mem_w ? {24'h000000, memory_ctrl_reg_ff} :
      hit_cfg_w ? {29'h00000000, pin_cfg_ff} : 32'h00000000;

   wire logic remap_w     = pin_cfg_ff[EBP_REMAP_BIT];
   wire logic shdn_tri_w  = pin_cfg_ff[EBP_SHDN_TRI_BIT];
   wire logic small_pkg_w = pin_cfg_ff[EBP_SMALL_PKG_BIT];

   // Small package has no address pins at all.
   wire logic nxt_ext_bus = !memory_ctrl_reg_ff[EBP_EXT_BUS_DIS_BIT]
                            && !small_pkg_w;

   // PWM sources in pin order 4..7: unit three C, three B, one C, one B.
   wire logic [3:0] pwm_src_w = {periph_in.pwm_one_out_b, periph_in.pwm_one_out_c,
                                 periph_in.pwm_three_out_b, periph_in.pwm_three_out_c};
   wire logic [3:0] pwm_shdn_w = {{2{periph_in.pwm_one_shutdown}},
                                  {2{periph_in.pwm_three_shutdown}}};

   logic [WIDTH-1:0] nxt_dout;
   logic [WIDTH-1:0] nxt_oe;

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_pin
         // Port data, replaced by parallel slave port data when that port is enabled.
         wire logic port_d = parallel_slave_port_en_in ? parallel_slave_port_data_in[gi]
                                                       : h_output_latch_ff[gi];
         wire logic dir_out = !h_direction_bits_ff[gi];
         if (gi < 4) begin : g_low
            // Address lines win over everything and ignore direction.
            assign nxt_dout[gi] = nxt_ext_bus ? periph_in.ext_addr[gi] : port_d;
            assign nxt_oe[gi]   = nxt_ext_bus ? 1'b1 : dir_out;
         end else begin : g_high
            // Analog selection is not consulted here, so output drive still works.
            wire logic pwm_on = !remap_w;
            assign nxt_dout[gi] = pwm_on ? pwm_src_w[gi-4] : port_d;
            assign nxt_oe[gi]   = dir_out &&
                                  !(pwm_on && shdn_tri_w && pwm_shdn_w[gi-4]);
         end
      end
   endgenerate

   // When remapped the PWM channels leave on the other port's bits 6:3.
   wire logic [3:0] nxt_alt_pwm = remap_w ? pwm_src_w : 4'h0;

   // Converter config field: lower values turn more channels analog; 0 means all analog.
   wire logic [3:0] nxt_analog_sel = analog_pin_config_ff[3:2] == 2'b11 ? 4'h0 :
                                     analog_pin_config_ff[3:2] == 2'b10 ? 4'h1 :
                                     analog_pin_config_ff[3:2] == 2'b01 ? 4'h3 : 4'hF;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         h_output_latch_ff    <= EBP_LATCH_RST;
         h_direction_bits_ff  <= EBP_DIR_RST;
         analog_pin_config_ff <= EBP_CONV_CFG_RST;
         memory_ctrl_reg_ff   <= EBP_MEM_CTRL_RST;
         pin_cfg_ff           <= EBP_PIN_CFG_RST;
      end else if (wr_w) begin
         if (hit_lat_w || hit_pin_w) begin
            h_output_latch_ff <= merge_lane(h_output_latch_ff, wbyte_w, 1'b1);
         end
         if (hit_dir_w) begin
            h_direction_bits_ff <= merge_lane(h_direction_bits_ff, wbyte_w, 1'b1);
         end
         if (hit_cnv_w) begin
            analog_pin_config_ff <= wbyte_w[3:0];
         end
         if (hit_mem_w) begin
            memory_ctrl_reg_ff <= merge_lane(memory_ctrl_reg_ff, wbyte_w, 1'b1);
         end
         if (hit_cfg_w) begin
            pin_cfg_ff <= wbyte_w[2:0];
         end
      end
   end

   // Pads are asynchronous; two flops before anything looks at them.
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         sync0_ff           <= '0;
         h_pin_level_reg_ff <= '0;
      end else begin
         sync0_ff           <= pad_in;
         h_pin_level_reg_ff <= sync0_ff;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         prdata_ff   <= 32'h00000000;
         pready_ff   <= 1'b0;
         pslverr_ff  <= 1'b0;
      end else begin
         pready_ff  <= setup_w;
         pslverr_ff <= setup_w && !mapped_w;
         prdata_ff  <= (setup_w && !pwrite_in) ? nxt_prdata : 32'h00000000;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         pad_ff        <= '{dout: '0, oe: '0};
         analog_sel_ff <= 4'hF;
         alt_pwm_ff    <= 4'h0;
         ext_bus_ff    <= 1'b0;
      end else begin
         pad_ff.dout   <= nxt_dout;
         pad_ff.oe     <= nxt_oe;
         analog_sel_ff <= nxt_analog_sel;
         alt_pwm_ff    <= nxt_alt_pwm;
         ext_bus_ff    <= nxt_ext_bus;
      end
   end

   assign prdata_out         = prdata_ff;
   assign pready_out         = pready_ff;
   assign pslverr_out        = pslverr_ff;
   assign pad_out            = pad_ff;
   assign analog_sel_out     = analog_sel_ff;
   assign alt_port_pwm_out   = alt_pwm_ff;
   assign ext_bus_active_out = ext_bus_ff;

endmodule

// File: testbench/ebp_port_monitor.sv
// Checker of bus timing and pin override behaviour of the port block.
`timescale 1ns/1ps
module ebp_port_monitor
   import ebp_pkg::*;
(
   // Clock, reset and bus.
   input wire logic        core_clk_in,
   input wire logic        rst_n_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   // Pins and overrides.
   input wire ebp_periph_t periph_in,
   input wire ebp_pad_t    pad_out,
   input wire logic [3:0]  analog_sel_out,
   input wire logic        ext_bus_active_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
      else $error("ready missing after setup");
   a_ready_one_cycle: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   a_unmapped_err: assert property (pready_out && paddr_in > 8'h14 |-> pslverr_out)
      else $error("unmapped access without error");
   a_err_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   a_idle_rdata: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("read data not zero when idle");
   // The address pins are registered straight from the memory interface.
   a_addr_pins: assert property (ext_bus_active_out && $past(ext_bus_active_out) |->
      pad_out.oe[3:0] == 4'hF && pad_out.dout[3:0] == $past(periph_in.ext_addr))
      else $error("address pins not driven");
   a_dir_reset: assert property ($rose(rst_n_in) |-> pad_out.oe == 8'h00 ##1 pad_out.oe == 8'h00)
      else $error("pins not inputs after reset");
   a_analog_reset: assert property ($rose(rst_n_in) |-> analog_sel_out == 4'hF)
      else $error("upper pins not analog after reset");
   cover property (ext_bus_active_out);
   cover property (pslverr_out);
   cover property (pready_out && pad_out.oe != 8'h00);
endmodule

bind ebp_port ebp_port_monitor u_mon (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
   .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .periph_in(periph_in),
   .pad_out(pad_out), .analog_sel_out(analog_sel_out), .ext_bus_active_out(ext_bus_active_out));

// File: testbench/ebp_pad_model.sv
// Board model: resolves each pin from the port driver or the board source.
`timescale 1ns/1ps
module ebp_pad_model
   import ebp_pkg::*;
(
   // Port drive and board source.
   input  wire ebp_pad_t   pad_in,
   input  wire logic [7:0] board_in,
   // Resolved pin levels.
   output logic      [7:0] level_out
);
   // The board only wins where the port driver is off.
   assign level_out = (pad_in.oe & pad_in.dout) | (~pad_in.oe & board_in);
endmodule

// File: testbench/ebp_port_test.sv
// Self-checking testbench of the eight-bit port block.
`timescale 1ns/1ps
module ebp_port_test
   import ebp_pkg::*;
;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        psp_en = 1'b0, pready, pslverr, ebus, er;
   logic [7:0]  paddr = 8'h00, psp_d = 8'h00, board = 8'h3C, level;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  asel, altp;
   ebp_periph_t per = '0;
   ebp_pad_t    pad;
   int          n_errors = 0, cmp_count = 0;
   always #10 clk = ~clk;
   ebp_port uut (.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .periph_in(per),
      .parallel_slave_port_en_in(psp_en), .parallel_slave_port_data_in(psp_d), .pad_in(level),
      .pad_out(pad), .analog_sel_out(asel), .alt_port_pwm_out(altp), .ext_bus_active_out(ebus));
   ebp_pad_model board_m (.pad_in(pad), .board_in(board), .level_out(level));
   task results();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("Error %0t: got %h expected %h", $time, s, e);
      end
   endtask
   // Holds the request until ready is seen at a falling edge.
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      // Ready is read while it stands, mid-cycle; the request is released on the next rising edge.
      @(negedge clk);
      while (pready !== 1'b1 && i < 50) begin
         @(negedge clk);
         i++;
      end
      if (i >= 50) begin
         n_errors++;
         results();
      end
      rd = prdata;
      er = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task t_reset();
      apb(0, 8'h04, 0); chk(rd[7:0], 8'h00);
      apb(0, 8'h08, 0); chk(rd[7:0], 8'hFF);
      apb(0, 8'h10, 0); chk(rd[7:0], 8'h80);
      chk(8'(asel), 8'hF);
   endtask
   task t_conv();
      logic [7:0] c[4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
      logic [3:0] e[4] = '{4'hF, 4'h3, 4'h1, 4'h0};
      for (int k = 0; k < 4; k++) begin
         apb(1, 8'h0C, c[k]); chk(8'(asel), 8'(e[k]));
      end
   endtask
   task t_dir();
      apb(1, 8'h04, 8'hA5); apb(1, 8'h08, 8'hF0);
      chk(pad.oe, 8'h0F); chk(8'(pad.dout[3:0]), 8'h5);
      apb(0, 8'h04, 0); chk(rd[7:0], 8'hA5);
      apb(0, 8'h00, 0); chk(rd[7:0], 8'h35);
   endtask
   task t_mem();
      apb(1, 8'h08, 8'hFF); per.ext_addr <= 4'h6; apb(1, 8'h10, 8'h00);
      chk(8'(ebus), 8'h1); chk(8'(pad.oe[3:0]), 8'hF);
      chk(8'(pad.dout[3:0]), 8'h6);
      apb(1, 8'h14, 8'h05); chk(8'(pad.oe[3:0]), 8'h0);
      apb(1, 8'h10, 8'h80); apb(1, 8'h14, 8'h01);
   endtask
   task t_pwm();
      per.pwm_one_out_b <= 1'b1; per.pwm_three_out_b <= 1'b1; psp_en <= 1'b1; psp_d <= 8'hFF;
      apb(1, 8'h04, 8'h00); apb(1, 8'h08, 8'h00); apb(1, 8'h14, 8'h00);
      chk(8'(pad.dout[7:4]), 8'hA); chk(8'(pad.oe[7:4]), 8'hF);
      per.pwm_one_shutdown <= 1'b1; apb(1, 8'h14, 8'h02);
      chk(8'(pad.oe[7:4]), 8'h3);
      per.pwm_one_shutdown <= 1'b0; psp_en <= 1'b0; apb(1, 8'h14, 8'h01);
      chk(8'(altp), 8'hA); chk(8'(pad.dout[7:4]), 8'h0);
   endtask
   task t_bad();
      apb(1, 8'h20, 8'h55); chk(8'(er), 8'h1); apb(0, 8'h20, 0); chk(rd[7:0], 8'h00);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset(); t_conv(); t_dir(); t_mem(); t_pwm(); t_bad();
      results();
   end
endmodule
